// [design/smrf_framer.sv]
// Purpose: receive message framing: start search, storing, termination
// Assumes: character and line inputs come from a receiver on sys_clk
// Notes: buffer is internal; stored bytes also stream out
//
// Notes on behaviour
// - Idle start waits for quiet line
// - Start char begins message, stored
// - Idle then start char, else reidle
// - Break is low beyond one character
// - Break start stores characters after break
// - Break then start char, else rebreak
// - Zero idle time starts immediately
// - Any-char message timer runs from launch
// - End char stored and terminates
// - Intercharacter timer restarts each character
// - Message timer starts at message start
// - Max count terminates, never overflow
// - Any end condition, first wins
// - Parity error terminates when enabled, except on the start char
// - Relaunch disarmed aborts at once
`timescale 1ns/100ps
module smrf_framer
  import smrf_pkg::*;
#(
  parameter int unsigned DEPTH = 255,
  parameter int unsigned CHAR_BITS_MAX = 12,
  parameter int unsigned TICKS = TICKS_PER_MS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Configuration and launch
  input wire smrf_cfg_t cfg,
  input wire logic launch,
  input wire logic [15:0] bitTicks,
  // Line side
  input wire logic rxLine,
  input wire smrf_char_t rxChar,
  // Message output
  output logic storeValid,
  output logic [7:0] storeData,
  output logic [7:0] storeIndex,
  output logic busy,
  output logic done,
  output smrf_end_t endReason,
  output logic [7:0] count
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WAIT_IDLE = 5'b00010,
    ST_WAIT_BREAK = 5'b00100,
    ST_WAIT_START = 5'b01000,
    ST_STORE = 5'b10000
  } smrf_state_t;

  smrf_state_t state_q;
  logic lineSync1_q, lineSync2_q;
  logic [31:0] lowCnt_q;
  logic breakSeen_q;
  logic [7:0] mem [DEPTH];
  logic idleExp, timeoutExp;
  logic idleRestart, toRestart, toRun;
  logic accept, storeNow;
  logic [31:0] breakLimit;

  // Line pin crosses in through two flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lineSync1_q <= 1'b1;
      lineSync2_q <= 1'b1;
    end else begin
      lineSync1_q <= rxLine;
      lineSync2_q <= lineSync1_q;
    end
  end

  assign breakLimit = 32'(bitTicks) * 32'(CHAR_BITS_MAX);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lowCnt_q <= 32'h00000000;
      breakSeen_q <= 1'b0;
    end else begin
      breakSeen_q <= 1'b0;
      if (lineSync2_q) begin
        lowCnt_q <= 32'h00000000;
      end else if (lowCnt_q <= breakLimit) begin
        lowCnt_q <= lowCnt_q + 32'h00000001;
        breakSeen_q <= (lowCnt_q == breakLimit);
      end
    end
  end

  assign idleRestart = (state_q != ST_WAIT_IDLE) || rxChar.valid || !lineSync2_q;
  smrf_ms_timer #(.TICKS(TICKS)) idleTimer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .restart(idleRestart),
    .run(1'b1),
    .limitMs(cfg.idleTimeMs),
    .expired(idleExp)
  );

  assign toRestart = (state_q == ST_STORE) && !cfg.timerIsMessage && rxChar.valid;
  assign toRun = (state_q == ST_STORE) && cfg.timerEnable;
  smrf_ms_timer #(.TICKS(TICKS)) endTimer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .restart(toRestart),
    .run(toRun),
    .limitMs(cfg.timeoutMs),
    .expired(timeoutExp)
  );

  assign accept = (state_q == ST_STORE) && rxChar.valid;

  // Framing state machine and termination
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      done <= 1'b0;
      endReason <= SMRF_END_NONE;
      count <= 8'h00;
      busy <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (launch && cfg.receiveArm) begin
            count <= 8'h00;
            endReason <= SMRF_END_NONE;
            busy <= 1'b1;
            if (cfg.breakStartEnable) begin
              state_q <= ST_WAIT_BREAK;
            end else if (cfg.idleStartEnable && cfg.idleTimeMs != MS_ZERO) begin
              state_q <= ST_WAIT_IDLE;
            end else if (cfg.startCharEnable && !cfg.idleStartEnable) begin
              state_q <= ST_WAIT_START;
            end else begin
              state_q <= ST_STORE;
            end
          end
        end
        ST_WAIT_IDLE: begin
          if (idleExp) begin
            state_q <= cfg.startCharEnable ? ST_WAIT_START : ST_STORE;
          end
        end
        ST_WAIT_BREAK: begin
          if (breakSeen_q) begin
            state_q <= cfg.startCharEnable ? ST_WAIT_START : ST_STORE;
          end
        end
        ST_WAIT_START: begin
          if (rxChar.valid) begin
            if (rxChar.data == cfg.startChar) begin
              state_q <= ST_STORE;
              count <= 8'h01;
              if (cfg.maxCount <= 8'h01) begin
                state_q <= ST_IDLE;
                busy <= 1'b0;
                done <= 1'b1;
                endReason <= SMRF_END_COUNT;
              end
            end else if (cfg.breakStartEnable) begin
              state_q <= ST_WAIT_BREAK;
            end else if (cfg.idleStartEnable) begin
              state_q <= ST_WAIT_IDLE;
            end
          end
        end
        ST_STORE: begin
          if (accept) begin
            count <= count + 8'h01;
          end
          if (accept && cfg.parityEnable && rxChar.parityError) begin
            state_q <= ST_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
            endReason <= SMRF_END_PARITY;
          end else if (accept && cfg.endCharEnable && rxChar.data == cfg.endChar) begin
            state_q <= ST_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
            endReason <= SMRF_END_CHAR;
          end else if (accept && (count + 8'h01) >= cfg.maxCount) begin
            state_q <= ST_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
            endReason <= SMRF_END_COUNT;
          end else if (timeoutExp) begin
            state_q <= ST_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
            endReason <= cfg.timerIsMessage ? SMRF_END_MSG : SMRF_END_ICHAR;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy <= 1'b0;
        end
      endcase
      if (launch && !cfg.receiveArm && state_q != ST_IDLE) begin
        state_q <= ST_IDLE;
        busy <= 1'b0;
        done <= 1'b1;
        endReason <= SMRF_END_ABORT;
      end
    end
  end

  // Store decision; count bound keeps the index inside the array
  assign storeNow = (accept || (state_q == ST_WAIT_START && rxChar.valid && rxChar.data == cfg.startChar))
                    && !(launch && !cfg.receiveArm) && 32'(count) < DEPTH;

  // Buffer write; stored bytes also stream out for the host
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      storeValid <= 1'b0;
      storeData <= 8'h00;
      storeIndex <= 8'h00;
    end else begin
      storeValid <= 1'b0;
      if (storeNow) begin
        storeValid <= 1'b1;
        storeData <= rxChar.data;
        storeIndex <= count;
      end
    end
  end

  // Buffer array has no reset; clearing every byte would cost logic for nothing
  always_ff @(posedge sys_clk) begin
    if (storeNow) begin
      mem[count] <= rxChar.data;
    end
  end

  property p_count_bound;
    @(posedge sys_clk) disable iff (!reset_n)
      (state_q == ST_STORE && cfg.maxCount != 8'h00) |-> count < cfg.maxCount;
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("count passed limit");

  property p_parity;
    @(posedge sys_clk) disable iff (!reset_n)
      (accept && cfg.parityEnable && rxChar.parityError && !launch) |=> (done && endReason == SMRF_END_PARITY);
  endproperty
  a_parity: assert property (p_parity) else $error("parity error not terminating");

  property p_abort;
    @(posedge sys_clk) disable iff (!reset_n)
      (launch && !cfg.receiveArm && busy) |=> (!busy && endReason == SMRF_END_ABORT);
  endproperty
  a_abort: assert property (p_abort) else $error("abort not taken");

  property p_no_store_break;
    @(posedge sys_clk) disable iff (!reset_n)
      (state_q == ST_WAIT_BREAK) |=> !storeValid;
  endproperty
  a_no_store_break: assert property (p_no_store_break) else $error("stored before break");

  // Nothing stored during the idle search
  property p_no_store_idle;
    @(posedge sys_clk) disable iff (!reset_n)
      (state_q == ST_WAIT_IDLE) |=> !storeValid;
  endproperty
  a_no_store_idle: assert property (p_no_store_idle) else $error("stored before idle line");

  property p_end_char;
    @(posedge sys_clk) disable iff (!reset_n)
      (accept && cfg.endCharEnable && rxChar.data == cfg.endChar && !(cfg.parityEnable && rxChar.parityError)
        && !launch) |=> (done && endReason == SMRF_END_CHAR);
  endproperty
  a_end_char: assert property (p_end_char) else $error("end character not terminating");
endmodule

// [design/smrf_ms_timer.sv]
// Purpose: restartable millisecond timer
// Assumes: restart and run come from logic on sys_clk
// Notes: expired is a level held until restart or run drops
`timescale 1ns/100ps
module smrf_ms_timer
  import smrf_pkg::*;
#(
  parameter int unsigned TICKS = TICKS_PER_MS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Control
  input wire logic restart,
  input wire logic run,
  input wire logic [15:0] limitMs,
  // Status
  output logic expired
);
  logic [31:0] tick_q;
  logic [15:0] ms_q;

  // Prescaler and millisecond count; a zero limit expires at once
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_q <= 32'h00000000;
      ms_q <= 16'h0000;
      expired <= 1'b0;
    end else if (restart || !run) begin
      tick_q <= 32'h00000000;
      ms_q <= 16'h0000;
      expired <= 1'b0;
    end else if (ms_q >= limitMs) begin
      expired <= 1'b1;
    end else if (tick_q == TICKS - 1) begin
      tick_q <= 32'h00000000;
      ms_q <= ms_q + 16'h0001;
    end else begin
      tick_q <= tick_q + 32'h00000001;
    end
  end
endmodule

// [design/smrf_pkg.sv]
// Purpose: shared constants and carriers for the serial message receive framer
// Assumes: 100 MHz sys_clk, millisecond timing
// Notes: configuration travels as one packed struct
package smrf_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned MS_UNIT = 1;
  localparam int unsigned TICKS_PER_MS = CLK_HZ / 1000 * MS_UNIT;
  localparam logic [7:0] MAX_COUNT_RESET = 8'h01;
  localparam logic [15:0] MS_ZERO = 16'h0000;

  // Receive control and framing settings
  typedef struct packed {
    logic receiveArm;
    logic idleStartEnable;
    logic startCharEnable;
    logic breakStartEnable;
    logic endCharEnable;
    logic timerEnable;
    logic timerIsMessage;
    logic parityEnable;
    logic [15:0] idleTimeMs;
    logic [15:0] timeoutMs;
    logic [7:0] startChar;
    logic [7:0] endChar;
    logic [7:0] maxCount;
  } smrf_cfg_t;

  // One received character from the line receiver
  typedef struct packed {
    logic valid;
    logic parityError;
    logic [7:0] data;
  } smrf_char_t;

  // End reasons
  typedef enum logic [2:0] {
    SMRF_END_NONE = 3'h0,
    SMRF_END_CHAR = 3'h1,
    SMRF_END_ICHAR = 3'h2,
    SMRF_END_MSG = 3'h3,
    SMRF_END_COUNT = 3'h4,
    SMRF_END_PARITY = 3'h5,
    SMRF_END_ABORT = 3'h6
  } smrf_end_t;
endpackage

// [tb/smrf_framer_tb_top.sv]
// Purpose: self-checking bench for the receive framer
// Assumes: TICKS 10 so one millisecond is 10 cycles; two cycles a bit
// Notes: stores are checked against a queue of expected bytes
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("unexpected %0t: %h vs %h", $time, a, b); end end
module smrf_framer_tb_top;
  import smrf_pkg::*;
  logic sys_clk = 1'b0, reset_n = 1'b0, launch = 1'b0, go = 1'b0, perrIn = 1'b0, doneSeen = 1'b0;
  logic [7:0] expB;
  logic rxLine, storeValid, busy, done;
  logic [7:0] byteIn = 8'h00, lowLen = 8'h03, storeData, storeIndex, count;
  smrf_cfg_t cfg = '0;
  smrf_char_t rxChar;
  smrf_end_t endReason;
  logic [7:0] expQ[$];
  int error_cnt = 0, n_tests = 0, cyc = 0, k = 0, expIdx = 0;
  integer seed = 31;
  smrf_framer #(.TICKS(10)) smrf_framer_inst (.sys_clk, .reset_n, .cfg, .launch, .bitTicks(16'h0002), .rxLine,
    .rxChar, .storeValid, .storeData, .storeIndex, .busy, .done, .endReason, .count);
  smrf_line_model smrf_line_model_inst (.sys_clk, .reset_n, .go, .byteIn, .perrIn, .lowLen, .rxLine, .rxChar);
  initial forever #5 sys_clk = ~sys_clk;
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Random payload stays clear of the start and end characters
  function automatic logic [7:0] rnd();
    return 8'(($random(seed) & 8'h3F) | 8'h40);
  endfunction
  task automatic base(input logic idle, input logic sc, input logic bk);
    cfg = '0;
    cfg.idleStartEnable = idle;
    cfg.startCharEnable = sc;
    cfg.breakStartEnable = bk;
    cfg.endCharEnable = 1'b1;
    cfg.startChar = 8'h3A;
    cfg.endChar = 8'h0D;
    cfg.maxCount = 8'hFF;
  endtask
  task automatic start(input logic arm = 1'b1);
    cfg.receiveArm = arm;
    launch = 1'b1;
    tick();
    launch = 1'b0;
  endtask
  task automatic snd(input logic [7:0] d, input logic keep, input logic pe = 1'b0, input logic [7:0] low = 8'h03);
    if (keep) expQ.push_back(d);
    byteIn = d;
    perrIn = pe;
    lowLen = low;
    go = 1'b1;
    tick();
    go = 1'b0;
    tick(int'(low) + 3);
  endtask
  task automatic fin(input smrf_end_t r, input int n, input string name);
    k = 0;
    while (doneSeen !== 1'b1 && k < 400) begin
      tick();
      k++;
    end
    // The done pulse may pass while a frame is still being sent, so the monitor latches it
    if (doneSeen !== 1'b1) begin
      error_cnt++;
      $display("unexpected %0t: reception never ended", $time);
    end
    `CHK(endReason, r)
    `CHK(busy, 1'b0)
    if (n >= 0) `CHK(count, n[7:0])
    `CHK(expQ.size(), 0)
    doneSeen = 1'b0;
    expIdx = 0;
    expQ.delete();
    tick(2);
    $display("test %s ended", name);
  endtask
  // Store monitor: every stored byte must match the oldest expectation
  // Sampled on the falling edge so outputs have settled since the launching edge
  always @(negedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end else begin
      if (done === 1'b1) doneSeen = 1'b1;
      if (storeValid === 1'b1) begin
        if (expQ.size() == 0) begin
          error_cnt++;
          $display("unexpected %0t: extra byte stored", $time);
        end else begin
          expB = expQ.pop_front();
          `CHK(storeData, expB)
          `CHK(storeIndex, expIdx[7:0])
        end
        expIdx++;
      end
    end
  end
  initial begin
    tick(6);
    reset_n = 1'b1;
    tick();
    base(1'b1, 1'b0, 1'b0);
    start();
    `CHK(busy, 1'b1)
    snd(rnd(), 1'b1);
    snd(rnd(), 1'b1);
    snd(8'h0D, 1'b1);
    fin(SMRF_END_CHAR, 3, "anychar");
    base(1'b0, 1'b1, 1'b0);
    cfg.maxCount = 8'h03;
    start();
    snd(rnd(), 1'b0);
    snd(8'h0D, 1'b0);
    snd(8'h3A, 1'b1);
    snd(rnd(), 1'b1);
    snd(rnd(), 1'b1);
    fin(SMRF_END_COUNT, 3, "startchar");
    base(1'b1, 1'b1, 1'b0);
    // Idle of 80 cycles is over three 24-cycle characters
    cfg.idleTimeMs = 16'h0008;
    start();
    snd(8'h3A, 1'b0);
    tick(100);
    snd(rnd(), 1'b0);
    snd(8'h3A, 1'b0);
    tick(100);
    snd(8'h3A, 1'b1);
    snd(8'h0D, 1'b1);
    fin(SMRF_END_CHAR, 2, "idlestart");
    base(1'b0, 1'b0, 1'b1);
    cfg.maxCount = 8'h02;
    start();
    snd(rnd(), 1'b0);
    snd(8'h00, 1'b0, 1'b0, 8'd20);
    snd(rnd(), 1'b0);
    snd(8'h00, 1'b0, 1'b0, 8'd40);
    snd(rnd(), 1'b1);
    snd(rnd(), 1'b1);
    fin(SMRF_END_COUNT, 2, "break");
    base(1'b0, 1'b1, 1'b1);
    start();
    snd(8'h00, 1'b0, 1'b0, 8'd40);
    snd(rnd(), 1'b0);
    snd(8'h3A, 1'b0);
    snd(8'h00, 1'b0, 1'b0, 8'd40);
    snd(8'h3A, 1'b1);
    snd(rnd(), 1'b1);
    snd(8'h0D, 1'b1);
    fin(SMRF_END_CHAR, 3, "breakstart");
    base(1'b1, 1'b0, 1'b0);
    cfg.timerEnable = 1'b1;
    cfg.timerIsMessage = 1'b1;
    cfg.timeoutMs = 16'h0003;
    start();
    fin(SMRF_END_MSG, 0, "msgtimer");
    `CHK(k >= 28 && k <= 34, 1'b1)
    base(1'b1, 1'b0, 1'b0);
    cfg.timerEnable = 1'b1;
    // 30 cycles is above one 24-cycle character
    cfg.timeoutMs = 16'h0003;
    start();
    repeat (4) snd(rnd(), 1'b1);
    fin(SMRF_END_ICHAR, 4, "ichar");
    base(1'b1, 1'b0, 1'b0);
    cfg.parityEnable = 1'b1;
    start();
    snd(rnd(), 1'b1);
    // The faulty character is still stored before reception ends
    snd(8'h0D, 1'b1, 1'b1);
    fin(SMRF_END_PARITY, 2, "parity");
    base(1'b1, 1'b0, 1'b0);
    start();
    snd(rnd(), 1'b1);
    start(1'b0);
    fin(SMRF_END_ABORT, 1, "abort");
    final_report();
  end
endmodule

// [tb/smrf_line_model.sv]
// Purpose: remote serial device driving the framer's line and character inputs
// Assumes: a frame is low for lowLen cycles, then one character strobe
// Notes: a frame of 16 or more low cycles carries no character (break)
`timescale 1ns/100ps
module smrf_line_model
  import smrf_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Frame request
  input wire logic go,
  input wire logic [7:0] byteIn,
  input wire logic perrIn,
  input wire logic [7:0] lowLen,
  // Line
  output logic rxLine,
  output smrf_char_t rxChar
);
  logic [7:0] lowCnt_q;
  logic [7:0] len_q;
  logic [7:0] byte_q;
  logic perr_q;
  // Line held low for the frame; data flips to its inverse each cycle outside go and a strobe
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lowCnt_q <= 8'h00;
      len_q <= 8'h00;
      byte_q <= 8'h00;
      perr_q <= 1'b0;
      rxLine <= 1'b1;
      rxChar <= '0;
    end else if (go) begin
      lowCnt_q <= lowLen;
      len_q <= lowLen;
      byte_q <= byteIn;
      perr_q <= perrIn;
      rxLine <= 1'b0;
    end else begin
      lowCnt_q <= (lowCnt_q != 8'h00) ? lowCnt_q - 8'h01 : 8'h00;
      rxLine <= (lowCnt_q > 8'h01) ? 1'b0 : 1'b1;
      rxChar <= '{valid: 1'b0, parityError: 1'b0, data: ~rxChar.data};
      if (lowCnt_q == 8'h01 && len_q < 8'h10) begin
        rxChar <= '{valid: 1'b1, parityError: perr_q, data: byte_q};
      end
    end
  end
endmodule
